// ===== rtl/ppom_pkg.sv
// package of constants for the port pin override mux
// assumes one io clock and an active-high asynchronous reset
`default_nettype none
package ppom_pkg;
  // ---------------------------------------------------------------
  // geometry and register map
  // ---------------------------------------------------------------
  localparam int          PPOM_PINS        = 4;
  localparam logic [7:0]  PPOM_ADR_DIR     = 8'h00;
  localparam logic [7:0]  PPOM_ADR_LATCH   = 8'h04;
  localparam logic [7:0]  PPOM_ADR_INPUT   = 8'h08;
  localparam logic [7:0]  PPOM_ADR_CTRL    = 8'h0c;
  localparam logic [7:0]  PPOM_ADR_STATUS  = 8'h10;
  localparam int          PPOM_CTRL_PUOFF  = 0;
  localparam int          PPOM_CTRL_SLEEP  = 1;
  localparam logic [3:0]  PPOM_DIR_RST     = 4'h0;
  localparam logic [3:0]  PPOM_LATCH_RST   = 4'h0;
  localparam logic [1:0]  PPOM_CTRL_RST    = 2'h0;
  // without pull-up override, pull-up is on only for {dir, latch, global off} equal to this
  localparam logic [2:0]  PPOM_PU_CODE     = 3'b010;
  // pin change source numbers carried by port a bits 0..3
  localparam int          PPOM_PCSRC_BASE  = 24;
endpackage : ppom_pkg
`default_nettype wire

// ===== rtl/ppom_mux.sv
// port a pin logic: registers, override muxing, pad drive and pull-ups
// assumes peripherals drive override enables/values synchronous to CLK;
// the pad wire is resolved outside from PAD_OUT and PAD_OE
//
// What this block does
// - pull-up override enable makes pull-up follow value
// - otherwise pull-up on when dir,latch,off = 010
// - direction override enable selects override driver enable
// - otherwise driver enable comes from direction bit
// - value override drives override value when enabled
// - otherwise driven value comes from output latch
// - toggle override inverts the output latch
// - input-enable override sets digital input enable
// - otherwise sleep clamps input, normal mode passes
// - raw input taken before synchronizer, users synchronise
// - analog path goes straight to pad, both ways
// - strobes per port, clock/sleep/pull-off shared, rest per pin
// - bit 3 feeds source 27, bit 2 source 26
// - bit 1 is analog channel 7, source 25
// - bit 0 is analog channel 6, source 24
// - writing one to input bit toggles latch
// - output latch one drives high, zero low
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
module ppom_mux
  import ppom_pkg::*;
(
  input  wire  logic                 CLK,
  input  wire  logic                 RST,
  // classic wishbone slave
  input  wire  logic                 WB_CYC_I,
  input  wire  logic                 WB_STB_I,
  input  wire  logic                 WB_WE_I,
  input  wire  logic [7:0]           WB_ADR_I,
  input  wire  logic [3:0]           WB_SEL_I,
  input  wire  logic [31:0]          WB_DAT_I,
  output var   logic [31:0]          WB_DAT_O,
  output var   logic                 WB_ACK_O,
  // per-pin overrides from peripherals
  input  wire  logic [PPOM_PINS-1:0] PULLUP_OVERRIDE_EN,
  input  wire  logic [PPOM_PINS-1:0] PULLUP_OVERRIDE_VAL,
  input  wire  logic [PPOM_PINS-1:0] DIR_OVERRIDE_EN,
  input  wire  logic [PPOM_PINS-1:0] DIR_OVERRIDE_VAL,
  input  wire  logic [PPOM_PINS-1:0] VALUE_OVERRIDE_EN,
  input  wire  logic [PPOM_PINS-1:0] VALUE_OVERRIDE_VAL,
  input  wire  logic [PPOM_PINS-1:0] TOGGLE_OVERRIDE_EN,
  input  wire  logic [PPOM_PINS-1:0] INPUT_EN_OVERRIDE_EN,
  input  wire  logic [PPOM_PINS-1:0] INPUT_EN_OVERRIDE_VAL,
  // pad side
  input  wire  logic [PPOM_PINS-1:0] PAD_IN,
  output var   logic [PPOM_PINS-1:0] PAD_OUT,
  output var   logic [PPOM_PINS-1:0] PAD_OE,
  output var   logic [PPOM_PINS-1:0] PAD_PULLUP,
  output var   logic [PPOM_PINS-1:0] PAD_INPUT_EN,
  // analog pass-through, both ways, pad resolves the wire
  input  wire  logic                 ANALOG_CHANNEL_7_IN,
  input  wire  logic                 ANALOG_CHANNEL_6_IN,
  output var   logic                 ANALOG_CHANNEL_7,
  output var   logic                 ANALOG_CHANNEL_6,
  // alternate raw inputs, unsynchronised
  output var   logic [PPOM_PINS-1:0] ALT_RAW_INPUT,
  output var   logic                 PIN_CHANGE_SRC_27,
  output var   logic                 PIN_CHANGE_SRC_26,
  output var   logic                 PIN_CHANGE_SRC_25,
  output var   logic                 PIN_CHANGE_SRC_24,
  output var   logic                 PORT_WRITE_STROBE,
  output var   logic                 PORT_READ_STROBE
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [PPOM_PINS-1:0] pin_direction_bit_ff;
  logic [PPOM_PINS-1:0] pin_output_latch_ff;
  logic [1:0]           ctrl_ff;
  logic [PPOM_PINS-1:0] sync1_ff;
  logic [PPOM_PINS-1:0] pin_input_reg_ff;
  logic                 ack_ff;
  logic [31:0]          rdata_ff;

  wire req       = WB_CYC_I & WB_STB_I & ~ack_ff;
  wire wr        = req & WB_WE_I & WB_SEL_I[0];
  wire wr_dir    = wr & (WB_ADR_I == PPOM_ADR_DIR);
  wire wr_latch  = wr & (WB_ADR_I == PPOM_ADR_LATCH);
  wire wr_input  = wr & (WB_ADR_I == PPOM_ADR_INPUT);
  wire wr_ctrl   = wr & (WB_ADR_I == PPOM_ADR_CTRL);
  wire rd        = req & ~WB_WE_I;
  wire pullup_global_off = ctrl_ff[PPOM_CTRL_PUOFF];
  wire sleep_clamp       = ctrl_ff[PPOM_CTRL_SLEEP];

  // one strobe per port shared by all pins
  assign PORT_WRITE_STROBE = wr;
  assign PORT_READ_STROBE  = rd;

  logic [31:0] rmux;
  always_comb begin
    case (WB_ADR_I)
      PPOM_ADR_DIR:    rmux = {28'h0, pin_direction_bit_ff};
      PPOM_ADR_LATCH:  rmux = {28'h0, pin_output_latch_ff};
      PPOM_ADR_INPUT:  rmux = {28'h0, pin_input_reg_ff};
      PPOM_ADR_CTRL:   rmux = {30'h0, ctrl_ff};
      PPOM_ADR_STATUS: rmux = {28'h0, PAD_OE};
      default:         rmux = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // per-pin override logic
  // ---------------------------------------------------------------
  logic [PPOM_PINS-1:0] nxt_latch;
  logic [PPOM_PINS-1:0] nxt_dir;

  for (genvar i = 0; i < PPOM_PINS; i++) begin : g_pin
    wire pu_norm = ({pin_direction_bit_ff[i], pin_output_latch_ff[i], pullup_global_off}
                    == PPOM_PU_CODE);
    assign PAD_PULLUP[i] = PULLUP_OVERRIDE_EN[i] ? PULLUP_OVERRIDE_VAL[i] : pu_norm;
    assign PAD_OE[i] = DIR_OVERRIDE_EN[i] ? DIR_OVERRIDE_VAL[i]
                                          : pin_direction_bit_ff[i];
    // value only reaches the pad through the enable
    assign PAD_OUT[i] = PAD_OE[i] & (VALUE_OVERRIDE_EN[i] ? VALUE_OVERRIDE_VAL[i]
                                                           : pin_output_latch_ff[i]);
    assign PAD_INPUT_EN[i] = INPUT_EN_OVERRIDE_EN[i] ? INPUT_EN_OVERRIDE_VAL[i]
                                                     : ~sleep_clamp;
    // raw input after clamp, before synchroniser
    assign ALT_RAW_INPUT[i] = PAD_IN[i] & PAD_INPUT_EN[i];
    wire tog = TOGGLE_OVERRIDE_EN[i] | (wr_input & WB_DAT_I[i]);
    assign nxt_latch[i] = wr_latch ? (WB_DAT_I[i] ^ TOGGLE_OVERRIDE_EN[i])
                                   : (pin_output_latch_ff[i] ^ tog);
    assign nxt_dir[i] = wr_dir ? WB_DAT_I[i] : pin_direction_bit_ff[i];
  end

  // ---------------------------------------------------------------
  // port a alternate assignments
  // ---------------------------------------------------------------
  assign PIN_CHANGE_SRC_27 = ALT_RAW_INPUT[3];
  assign PIN_CHANGE_SRC_26 = ALT_RAW_INPUT[2];
  assign PIN_CHANGE_SRC_25 = ALT_RAW_INPUT[1];
  assign PIN_CHANGE_SRC_24 = ALT_RAW_INPUT[0];
  assign ANALOG_CHANNEL_7  = ANALOG_CHANNEL_7_IN;
  assign ANALOG_CHANNEL_6  = ANALOG_CHANNEL_6_IN;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_direction_bit_ff <= PPOM_DIR_RST;
      pin_output_latch_ff  <= PPOM_LATCH_RST;
      ctrl_ff              <= PPOM_CTRL_RST;
    end else begin
      pin_direction_bit_ff <= nxt_dir;
      pin_output_latch_ff  <= nxt_latch;
      if (wr_ctrl) begin
        ctrl_ff <= WB_DAT_I[1:0];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_ff         <= '0;
      pin_input_reg_ff <= '0;
    end else begin
      sync1_ff         <= ALT_RAW_INPUT;
      pin_input_reg_ff <= sync1_ff;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff   <= req;
      rdata_ff <= rd ? rmux : 32'h0;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdata_ff;

endmodule // ppom_mux
`default_nettype wire

// ===== verif/ppom_mux_properties.sv
// concurrent checks on the port pin override mux ports
// assumes binding to ppom_mux, one clock, active-high reset
`default_nettype none
module ppom_mux_properties
  import ppom_pkg::*;
(
  input wire logic                 CLK, RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, PORT_WRITE_STROBE,
  input wire logic                 PORT_READ_STROBE,
  input wire logic                 ANALOG_CHANNEL_7_IN, ANALOG_CHANNEL_6_IN, ANALOG_CHANNEL_7, ANALOG_CHANNEL_6,
  input wire logic                 PIN_CHANGE_SRC_27, PIN_CHANGE_SRC_26, PIN_CHANGE_SRC_25, PIN_CHANGE_SRC_24,
  input wire logic [PPOM_PINS-1:0] PULLUP_OVERRIDE_EN, PULLUP_OVERRIDE_VAL, DIR_OVERRIDE_EN, DIR_OVERRIDE_VAL,
  input wire logic [PPOM_PINS-1:0] VALUE_OVERRIDE_EN, VALUE_OVERRIDE_VAL, INPUT_EN_OVERRIDE_EN,
  input wire logic [PPOM_PINS-1:0] INPUT_EN_OVERRIDE_VAL, PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP, PAD_INPUT_EN,
  input wire logic [PPOM_PINS-1:0] ALT_RAW_INPUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_pu; ((PAD_PULLUP ^ PULLUP_OVERRIDE_VAL) & PULLUP_OVERRIDE_EN) == 0; endproperty
  a_pu: assert property (p_pu) else $error("pull-up ignores override");
  property p_dir; ((PAD_OE ^ DIR_OVERRIDE_VAL) & DIR_OVERRIDE_EN) == 0; endproperty
  a_dir: assert property (p_dir) else $error("driver enable ignores override");
  property p_val; ((PAD_OUT ^ VALUE_OVERRIDE_VAL) & VALUE_OVERRIDE_EN & PAD_OE) == 0; endproperty
  a_val: assert property (p_val) else $error("pin value ignores override");
  property p_off; (PAD_OUT & ~PAD_OE) == 0; endproperty
  a_off: assert property (p_off) else $error("value shown while undriven");
  property p_ien; ((PAD_INPUT_EN ^ INPUT_EN_OVERRIDE_VAL) & INPUT_EN_OVERRIDE_EN) == 0; endproperty
  a_ien: assert property (p_ien) else $error("input enable ignores override");
  property p_raw; ALT_RAW_INPUT == (PAD_IN & PAD_INPUT_EN) && ALT_RAW_INPUT ==
    {PIN_CHANGE_SRC_27, PIN_CHANGE_SRC_26, PIN_CHANGE_SRC_25, PIN_CHANGE_SRC_24}; endproperty
  a_raw: assert property (p_raw) else $error("raw input or source mapping wrong");
  property p_ana; ANALOG_CHANNEL_7 == ANALOG_CHANNEL_7_IN && ANALOG_CHANNEL_6 == ANALOG_CHANNEL_6_IN; endproperty
  a_ana: assert property (p_ana) else $error("analog path not direct");
  property p_wr; WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O |-> PORT_WRITE_STROBE ##1 WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe or ack timing wrong");
  property p_rd; WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O |-> PORT_READ_STROBE && !PORT_WRITE_STROBE;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe wrong");
endmodule // ppom_mux_properties
bind ppom_mux ppom_mux_properties i_chk (.*);
`default_nettype wire

// ===== verif/ppom_pad.sv
// pad model: resolves the pin level seen back by the mux
// assumes a weak outside level that the pull-up can lift
`default_nettype none
module ppom_pad
  import ppom_pkg::*;
(
  input  wire logic [PPOM_PINS-1:0] pad_out, pad_oe, pad_pullup, ext_level,
  output logic      [PPOM_PINS-1:0] pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | ext_level));
endmodule // ppom_pad
`default_nettype wire

// ===== verif/port_pin_override_mux_test.sv
// self-checking bench for the port pin override mux
// assumes ppom_pkg, the pad model and the checker are compiled first
`default_nettype none
module port_pin_override_mux_test
  import ppom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, WB_ACK_O, PORT_WRITE_STROBE, PORT_READ_STROBE;
  logic ANALOG_CHANNEL_7_IN = 0, ANALOG_CHANNEL_6_IN = 0, ANALOG_CHANNEL_7, ANALOG_CHANNEL_6;
  logic PIN_CHANGE_SRC_27, PIN_CHANGE_SRC_26, PIN_CHANGE_SRC_25, PIN_CHANGE_SRC_24;
  logic [7:0] WB_ADR_I = 0;
  logic [31:0] WB_DAT_I = 0, WB_DAT_O, q;
  logic [3:0] WB_SEL_I = 0, PULLUP_OVERRIDE_EN = 0, PULLUP_OVERRIDE_VAL = 0, DIR_OVERRIDE_EN = 0, DIR_OVERRIDE_VAL = 0;
  logic [3:0] VALUE_OVERRIDE_EN = 0, VALUE_OVERRIDE_VAL = 0, TOGGLE_OVERRIDE_EN = 0, INPUT_EN_OVERRIDE_EN = 0;
  logic [3:0] INPUT_EN_OVERRIDE_VAL = 0, PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP, PAD_INPUT_EN, ALT_RAW_INPUT;
  logic [3:0] pad_ext = 4'hb;
  int num_errors = 0, cmp_count = 0;
  always #25 CLK = ~CLK;
  ppom_mux i_dut (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O,
    .WB_ACK_O, .PULLUP_OVERRIDE_EN, .PULLUP_OVERRIDE_VAL, .DIR_OVERRIDE_EN, .DIR_OVERRIDE_VAL, .VALUE_OVERRIDE_EN,
    .VALUE_OVERRIDE_VAL, .TOGGLE_OVERRIDE_EN, .INPUT_EN_OVERRIDE_EN, .INPUT_EN_OVERRIDE_VAL, .PAD_IN, .PAD_OUT,
    .PAD_OE, .PAD_PULLUP, .PAD_INPUT_EN, .ANALOG_CHANNEL_7_IN, .ANALOG_CHANNEL_6_IN, .ANALOG_CHANNEL_7,
    .ANALOG_CHANNEL_6, .ALT_RAW_INPUT, .PIN_CHANGE_SRC_27, .PIN_CHANGE_SRC_26, .PIN_CHANGE_SRC_25,
    .PIN_CHANGE_SRC_24, .PORT_WRITE_STROBE, .PORT_READ_STROBE);
  ppom_pad i_pad (.pad_out(PAD_OUT), .pad_oe(PAD_OE), .pad_pullup(PAD_PULLUP), .ext_level(pad_ext), .pad_in(PAD_IN));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // classic single cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, WB_SEL_I} <= {2'b11, we, a, d, 4'hf};
    do @(posedge CLK); while (WB_ACK_O !== 1'b1 && ++n < 20);
    if (WB_ACK_O !== 1'b1) num_errors++;
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'b00;
    @(posedge CLK);
  endtask
  task automatic s_reset();
    wb(0, PPOM_ADR_DIR, 0); chk(q, 0);
    wb(0, 8'h40, 0); chk(q, 0);
    chk(PAD_INPUT_EN, 4'hf);
  endtask
  task automatic s_pullup();
    for (int c = 0; c < 8; c++) begin
      wb(1, PPOM_ADR_DIR, {28'h0, {4{c[2]}}});
      wb(1, PPOM_ADR_LATCH, {28'h0, {4{c[1]}}});
      wb(1, PPOM_ADR_CTRL, {31'h0, c[0]});
      chk(PAD_PULLUP, (c == 2) ? 4'hf : 4'h0);
    end
    {PULLUP_OVERRIDE_EN, PULLUP_OVERRIDE_VAL} <= 8'h31;
    @(posedge CLK); chk(PAD_PULLUP, 4'h1);
    PULLUP_OVERRIDE_EN <= 0;
  endtask
  task automatic s_drive();
    wb(1, PPOM_ADR_DIR, 5); wb(1, PPOM_ADR_LATCH, 3); wb(1, PPOM_ADR_CTRL, 0);
    chk(PAD_OE, 4'h5); chk(PAD_OUT, 4'h1);
    {DIR_OVERRIDE_EN, DIR_OVERRIDE_VAL} <= 8'hfa;
    @(posedge CLK); chk(PAD_OE, 4'ha); chk(PAD_OUT, 4'h2);
    {VALUE_OVERRIDE_EN, VALUE_OVERRIDE_VAL} <= 8'hfc;
    @(posedge CLK); chk(PAD_OUT, 4'h8);
    {DIR_OVERRIDE_EN, VALUE_OVERRIDE_EN} <= 0;
    @(posedge CLK);
  endtask
  task automatic s_toggle();
    wb(1, PPOM_ADR_INPUT, 1); wb(0, PPOM_ADR_LATCH, 0); chk(q[3:0], 4'h2);
    TOGGLE_OVERRIDE_EN <= 4'h4;
    @(posedge CLK); TOGGLE_OVERRIDE_EN <= 0;
    wb(0, PPOM_ADR_LATCH, 0); chk(q[3:0], 4'h6);
  endtask
  task automatic s_input();
    wb(1, PPOM_ADR_DIR, 0); wb(1, PPOM_ADR_LATCH, 0); wb(1, PPOM_ADR_CTRL, 2);
    chk(PAD_INPUT_EN, 4'h0);
    {INPUT_EN_OVERRIDE_EN, INPUT_EN_OVERRIDE_VAL, ANALOG_CHANNEL_7_IN} <= 9'h1eb;
    @(posedge CLK); chk(PAD_INPUT_EN, 4'h5); chk(ALT_RAW_INPUT, 4'h1);
    chk({PIN_CHANGE_SRC_27, PIN_CHANGE_SRC_26, PIN_CHANGE_SRC_25, PIN_CHANGE_SRC_24}, 4'h1);
    chk({ANALOG_CHANNEL_7, ANALOG_CHANNEL_6}, 2'b10);
    @(posedge CLK);
    wb(0, PPOM_ADR_INPUT, 0); chk(q[3:0], 4'h1);
  endtask
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge CLK);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    s_reset(); s_pullup(); s_drive(); s_toggle(); s_input();
    print_verdict();
  end
endmodule // port_pin_override_mux_test
`default_nettype wire
